// file: event_status_pkg.sv
package event_status_pkg;

  // ==========================================
  // event bit positions
  localparam int BIT_OP_DONE   = 0;
  localparam int BIT_BUS_CTRL  = 1;
  localparam int BIT_QUERY_ERR = 2;
  localparam int BIT_HW_FAULT  = 3;
  localparam int BIT_EXEC_ERR  = 4;
  localparam int BIT_SYNTAX    = 5;
  localparam int BIT_USER_KEY  = 6;
  localparam int BIT_POWER_ON  = 7;
  localparam int SUMMARY_POS   = 5;

  // ==========================================
  // reset values and error codes
  localparam logic [7:0] STATUS_RESET   = 8'h80;
  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [7:0] CODE_NONE      = 8'h00;
  localparam logic [7:0] CODE_LOCAL     = 8'h15;
  localparam logic [7:0] CODE_PARAMS    = 8'h19;
  localparam logic [7:0] CODE_UNIMPL    = 8'h1a;
  localparam logic [7:0] RESERVED_HIGH  = 8'h00;

  // ==========================================
  // decoded commands and queries
  typedef enum logic [2:0] {
    OP_SET_ENABLE,
    OP_GET_ENABLE,
    OP_GET_STATUS,
    OP_GET_EXEC_ERR,
    OP_OP_COMPLETE,
    OP_GET_KEY,
    OP_GET_PARSER,
    OP_UNKNOWN
  } op_t;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } state_t;

  typedef struct packed {
    op_t        op;
    logic       extra;
    logic [7:0] value;
  } cmd_t;

  typedef struct packed {
    logic       key_press;
    logic [7:0] key_id;
    logic       syntax_err;
    logic [7:0] syntax_code;
    logic       exec_err;
    logic [7:0] exec_code;
    logic       hw_fault;
    logic       query_err;
  } events_t;

endpackage : event_status_pkg

// file: answer_buffer.sv
`timescale 1ns/100ps
module answer_buffer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // load and flush
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_data_i,
  input  wire logic             flush_i,
  // reader side
  input  wire logic             read_i,
  output logic                  valid_o,
  output logic [WIDTH-1:0]      data_o,
  // error pulses
  output logic                  empty_read_o,
  output logic                  flushed_o
);

  // elaboration check: an answer must hold at least one byte
  if (WIDTH < 8) begin : g_width_check
    $error("answer_buffer: WIDTH below 8");
  end

  logic             valid_q;
  logic             valid_d;
  logic [WIDTH-1:0] data_q;
  logic [WIDTH-1:0] data_d;

  // ==========================================
  // single answer slot
  always_comb begin
    valid_d = valid_q;
    data_d  = data_q;
    if (read_i || flush_i) begin
      valid_d = 1'b0;
    end
    if (load_i) begin
      valid_d = 1'b1;
      data_d  = load_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_q <= 1'b0;
      data_q  <= '0;
    end else begin
      valid_q <= valid_d;
      data_q  <= data_d;
    end
  end

  assign valid_o      = valid_q;
  assign data_o       = data_q;
  assign empty_read_o = read_i && !valid_q;
  assign flushed_o    = flush_i && valid_q;

endmodule : answer_buffer

// file: event_status_reporting.sv
`timescale 1ns/100ps
module event_status_reporting (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  // command port
  input  wire logic                      cmd_valid_i,
  input  wire event_status_pkg::cmd_t    cmd_i,
  output logic                           cmd_ready_o,
  // answer port
  input  wire logic                      rsp_read_i,
  output logic                           rsp_valid_o,
  output logic [15:0]                    rsp_data_o,
  // device events
  input  wire event_status_pkg::events_t events_i,
  input  wire logic                      local_mode_i,
  // status
  output logic                           summary_o
);

  // ==========================================
  // reset release
  logic [1:0] rst_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ==========================================
  // command sequencing
  event_status_pkg::state_t state_q;
  event_status_pkg::state_t state_d;
  event_status_pkg::cmd_t   cmd_q;
  event_status_pkg::cmd_t   cmd_d;
  logic                     ready_q;
  logic                     ready_d;
  logic                     take;
  logic                     exec;

  assign take = cmd_valid_i && ready_q;
  assign exec = (state_q == event_status_pkg::ST_EXEC);

  always_comb begin
    state_d = state_q;
    cmd_d   = cmd_q;
    ready_d = ready_q;
    unique case (state_q)
      event_status_pkg::ST_IDLE: begin
        if (take) begin
          state_d = event_status_pkg::ST_EXEC;
          cmd_d   = cmd_i;
          ready_d = 1'b0;
        end
      end
      event_status_pkg::ST_EXEC: begin
        state_d = event_status_pkg::ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= event_status_pkg::ST_IDLE;
      cmd_q   <= '0;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      ready_q <= ready_d;
    end
  end

  // ==========================================
  // execution and its error code
  logic       int_err;
  logic [7:0] int_code;
  logic       done_ok;

  always_comb begin
    int_err  = 1'b0;
    int_code = event_status_pkg::CODE_NONE;
    if (exec) begin
      if (cmd_q.op == event_status_pkg::OP_UNKNOWN) begin
        int_err  = 1'b1;
        int_code = event_status_pkg::CODE_UNIMPL;
      end else if (cmd_q.extra) begin
        int_err  = 1'b1;
        int_code = event_status_pkg::CODE_PARAMS;
      end else if (local_mode_i && cmd_q.op == event_status_pkg::OP_SET_ENABLE) begin
        int_err  = 1'b1;
        int_code = event_status_pkg::CODE_LOCAL;
      end
    end
  end
  assign done_ok = exec && !int_err;

  // ==========================================
  // status registers
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] enable_q;
  logic [7:0] enable_d;
  logic [7:0] exec_code_q;
  logic [7:0] exec_code_d;
  logic [7:0] key_code_q;
  logic [7:0] key_code_d;
  logic [7:0] parser_code_q;
  logic [7:0] parser_code_d;
  logic       summary_q;
  logic       summary_d;
  logic [7:0] ev;
  logic       rd_status;
  logic       rd_exec;
  logic       rd_key;
  logic       rd_parser;
  logic       empty_read;
  logic       flushed;
  logic       load;
  logic [15:0] load_data;

  assign rd_status = done_ok && cmd_q.op == event_status_pkg::OP_GET_STATUS;
  assign rd_exec   = done_ok && cmd_q.op == event_status_pkg::OP_GET_EXEC_ERR;
  assign rd_key    = done_ok && cmd_q.op == event_status_pkg::OP_GET_KEY;
  assign rd_parser = done_ok && cmd_q.op == event_status_pkg::OP_GET_PARSER;

  always_comb begin
    ev = 8'h00;
    ev[event_status_pkg::BIT_USER_KEY]  = events_i.key_press;
    ev[event_status_pkg::BIT_SYNTAX]    = events_i.syntax_err;
    ev[event_status_pkg::BIT_EXEC_ERR]  = events_i.exec_err || int_err;
    ev[event_status_pkg::BIT_HW_FAULT]  = events_i.hw_fault;
    ev[event_status_pkg::BIT_QUERY_ERR] = events_i.query_err || empty_read || flushed;
    ev[event_status_pkg::BIT_OP_DONE]   = done_ok && cmd_q.op == event_status_pkg::OP_OP_COMPLETE;
  end

  always_comb begin
    // read clears, new events still land
    status_d = (rd_status ? 8'h00 : status_q) | ev;
    status_d[event_status_pkg::BIT_BUS_CTRL] = 1'b0;
    enable_d = (done_ok && cmd_q.op == event_status_pkg::OP_SET_ENABLE) ?
               cmd_q.value : enable_q;
    // latest code, cleared by its read
    exec_code_d = rd_exec ? event_status_pkg::CODE_NONE : exec_code_q;
    if (int_err) begin
      exec_code_d = int_code;
    end else if (events_i.exec_err) begin
      exec_code_d = events_i.exec_code;
    end
    key_code_d = rd_key ? 8'h00 : key_code_q;
    if (events_i.key_press) begin
      key_code_d = events_i.key_id;
    end
    parser_code_d = rd_parser ? 8'h00 : parser_code_q;
    if (events_i.syntax_err) begin
      parser_code_d = events_i.syntax_code;
    end
    // taken from next values, so no lag
    summary_d = |(status_d & enable_d);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_q      <= event_status_pkg::STATUS_RESET;
      enable_q      <= event_status_pkg::ENABLE_RESET;
      exec_code_q   <= event_status_pkg::CODE_NONE;
      key_code_q    <= 8'h00;
      parser_code_q <= 8'h00;
      summary_q     <= 1'b0;
    end else begin
      status_q      <= status_d;
      enable_q      <= enable_d;
      exec_code_q   <= exec_code_d;
      key_code_q    <= key_code_d;
      parser_code_q <= parser_code_d;
      summary_q     <= summary_d;
    end
  end

  // ==========================================
  // answers
  always_comb begin
    load      = done_ok;
    load_data = 16'h0000;
    unique case (cmd_q.op)
      event_status_pkg::OP_GET_ENABLE:   load_data = {8'h00, enable_q};
      event_status_pkg::OP_GET_STATUS:   load_data = {event_status_pkg::RESERVED_HIGH, status_q};
      event_status_pkg::OP_GET_EXEC_ERR: load_data = {8'h00, exec_code_q};
      event_status_pkg::OP_GET_KEY:      load_data = {8'h00, key_code_q};
      event_status_pkg::OP_GET_PARSER:   load_data = {8'h00, parser_code_q};
      default:                           load = 1'b0;
    endcase
  end

  // new command flushes an unread answer
  answer_buffer #(
    .WIDTH (16)
  ) u_answer (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n),
    .load_i       (load),
    .load_data_i  (load_data),
    .flush_i      (take && !rsp_read_i),
    .read_i       (rsp_read_i),
    .valid_o      (rsp_valid_o),
    .data_o       (rsp_data_o),
    .empty_read_o (empty_read),
    .flushed_o    (flushed)
  );

  assign cmd_ready_o = ready_q;
  assign summary_o   = summary_q;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence set_mask_s;
    exec && !int_err && cmd_q.op == event_status_pkg::OP_SET_ENABLE;
  endsequence
  sequence taken_s;
    take ##1 exec;
  endsequence

  mask_store_a: assert property (set_mask_s |=> enable_q == $past(cmd_q.value))
    else $error("mask not stored");
  summary_tie_a: assert property (summary_o == |(status_q & enable_q))
    else $error("summary bit wrong");
  status_read_a: assert property (rd_status |=> rsp_valid_o && rsp_data_o[15:8] == 8'h00
      && rsp_data_o[7:0] == $past(status_q) && status_q == $past(status_d))
    else $error("status read or clear wrong");
  power_on_a: assert property ($rose(rst_n) |-> status_q[event_status_pkg::BIT_POWER_ON])
    else $error("power-on bit missing");
  key_latch_a: assert property (events_i.key_press |=> status_q[event_status_pkg::BIT_USER_KEY]
      && key_code_q == $past(events_i.key_id))
    else $error("key event lost");
  unimpl_code_a: assert property (exec && cmd_q.op == event_status_pkg::OP_UNKNOWN
      |=> exec_code_q == event_status_pkg::CODE_UNIMPL
      && status_q[event_status_pkg::BIT_EXEC_ERR])
    else $error("unimplemented code wrong");
  empty_read_a: assert property (rsp_read_i && !rsp_valid_o
      |=> status_q[event_status_pkg::BIT_QUERY_ERR])
    else $error("empty read not flagged");
  bus_ctrl_a: assert property (!status_q[event_status_pkg::BIT_BUS_CTRL])
    else $error("bus control bit set");
  one_cmd_a: assert property (taken_s |-> !cmd_ready_o ##1 cmd_ready_o)
    else $error("command overlap");
  exec_clear_a: assert property (rd_exec && !events_i.exec_err
      |=> exec_code_q == 8'h00 && rsp_data_o[7:0] == $past(exec_code_q))
    else $error("exec register not cleared");

endmodule : event_status_reporting

// file: remote_controller.sv
`timescale 1ns/100ps
module remote_controller (
  // clock
  input  wire logic                   clk_i,
  // command side
  output logic                        cmd_valid_o,
  output event_status_pkg::cmd_t      cmd_o,
  input  wire logic                   cmd_ready_i,
  // answer side
  output logic                        rsp_read_o,
  input  wire logic                   rsp_valid_i,
  input  wire logic [15:0]            rsp_data_i
);
  // ==========================================
  // pacing: idle cycles before each send and fetch, raised for a slow controller
  int gap = 0;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_o       = '0;
    rsp_read_o  = 1'b0;
  end

  // ==========================================
  // command request, held until ready is seen or 20 cycles have passed
  task automatic send(input event_status_pkg::op_t op, input logic extra, input logic [7:0] v);
    int n;
    n = 0;
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o       <= '{op: op, extra: extra, value: v};
    do begin
      @(posedge clk_i);
      n++;
    end while (!cmd_ready_i && n < 20);
    cmd_valid_o <= 1'b0;
    // released bus: no stale command left on it
    cmd_o       <= ~cmd_o;
  endtask : send

  // ==========================================
  // answer fetch; a missing answer still reads, which the device must flag
  task automatic fetch(output logic [15:0] d);
    int n;
    n = 0;
    d = '1;
    repeat (gap) @(posedge clk_i);
    do begin
      @(posedge clk_i);
      n++;
    end while (!rsp_valid_i && n < 20);
    if (rsp_valid_i) d = rsp_data_i;
    rsp_read_o <= 1'b1;
    @(posedge clk_i);
    rsp_read_o <= 1'b0;
  endtask : fetch

  task automatic stray_read;
    @(posedge clk_i);
    rsp_read_o <= 1'b1;
    @(posedge clk_i);
    rsp_read_o <= 1'b0;
  endtask : stray_read
endmodule : remote_controller

// file: test_event_status_reporting.sv
`timescale 1ns/100ps
module test_event_status_reporting;
  // ==========================================
  // clock, reset and wiring
  logic                      clk_i      = 1'b0;
  logic                      arst_n_i   = 1'b0;
  logic                      cmd_valid;
  event_status_pkg::cmd_t    cmd_w;
  logic                      cmd_ready;
  logic                      rsp_read;
  logic                      rsp_valid;
  logic [15:0]               rsp_data;
  event_status_pkg::events_t ev         = '0;
  logic                      local_mode = 1'b0;
  logic                      summary;
  int                        num_errors = 0;
  int                        compares   = 0;
  logic [15:0]               got;
  logic [7:0]                masks [4]  = '{8'h00, 8'hff, 8'h48, 8'ha5};
  logic [7:0]                wt [5]     = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04};
  logic [7:0]                codes [3]  = '{8'h15, 8'h19, 8'h1a};

  always #5 clk_i = ~clk_i;

  event_status_reporting uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid),
    .cmd_i(cmd_w), .cmd_ready_o(cmd_ready), .rsp_read_i(rsp_read), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .events_i(ev), .local_mode_i(local_mode), .summary_o(summary));

  remote_controller ctrl (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd_w),
    .cmd_ready_i(cmd_ready), .rsp_read_o(rsp_read), .rsp_valid_i(rsp_valid),
    .rsp_data_i(rsp_data));

  // ==========================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cmd(input event_status_pkg::op_t op, input logic x, input logic [7:0] v);
    ctrl.send(op, x, v);
    #1;
    check("ready after take", {15'h0000, cmd_ready}, 16'h0000);
  endtask : cmd

  task automatic query(input event_status_pkg::op_t op, output logic [15:0] d);
    cmd(op, 1'b0, 8'h00);
    ctrl.fetch(d);
  endtask : query

  task automatic status_is(input string what, input logic [7:0] exp);
    query(event_status_pkg::OP_GET_STATUS, got);
    check(what, got, {8'h00, exp});
  endtask : status_is

  task automatic pulse(input event_status_pkg::events_t e);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= '0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : pulse

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================
  // watchdog: the sequence needs a few hundred cycles
  initial begin
    #200us;
    num_errors++;
    report_and_stop();
  end

  // ==========================================
  // main sequence
  initial begin
    event_status_pkg::events_t e;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    status_is("status at power-up", 8'h80);
    status_is("status after read", 8'h00);
    foreach (masks[i]) begin
      cmd(event_status_pkg::OP_SET_ENABLE, 1'b0, masks[i]);
      query(event_status_pkg::OP_GET_ENABLE, got);
      check("enable mask", got, {8'h00, masks[i]});
    end
    // mask a5 stays: syntax and query error reach the summary, the others do not
    for (int i = 0; i < 5; i++) begin
      e = '0;
      e.key_press   = (i == 0);
      e.key_id      = 8'h3c;
      e.syntax_err  = (i == 1);
      e.syntax_code = 8'h2b;
      e.exec_err    = (i == 2);
      e.exec_code   = 8'h17;
      e.hw_fault    = (i == 3);
      e.query_err   = (i == 4);
      pulse(e);
      check("summary", {15'h0000, summary}, {15'h0000, |(wt[i] & 8'ha5)});
      status_is("event weight", wt[i]);
      check("summary after clear", {15'h0000, summary}, 16'h0000);
    end
    query(event_status_pkg::OP_GET_KEY, got);
    check("key register", got, 16'h003c);
    query(event_status_pkg::OP_GET_PARSER, got);
    check("parser register", got, 16'h002b);
    query(event_status_pkg::OP_GET_EXEC_ERR, got);
    check("exec code", got, 16'h0017);
    query(event_status_pkg::OP_GET_EXEC_ERR, got);
    check("exec code cleared", got, 16'h0000);
    // slow controller from here on
    ctrl.gap = 3;
    cmd(event_status_pkg::OP_OP_COMPLETE, 1'b0, 8'h00);
    #20;
    check("summary on done", {15'h0000, summary}, 16'h0001);
    status_is("operation complete", 8'h01);
    e = '0;
    e.hw_fault = 1'b1;
    pulse(e);
    check("summary masked", {15'h0000, summary}, 16'h0000);
    cmd(event_status_pkg::OP_SET_ENABLE, 1'b0, 8'h08);
    #20;
    check("summary on mask", {15'h0000, summary}, 16'h0001);
    status_is("hardware fault", 8'h08);
    for (int i = 0; i < 3; i++) begin
      local_mode <= (i == 0);
      cmd(i == 2 ? event_status_pkg::OP_UNKNOWN : event_status_pkg::OP_SET_ENABLE, i == 1, 8'hff);
      query(event_status_pkg::OP_GET_EXEC_ERR, got);
      // local mode must still stand in the execute cycle of the refused command
      local_mode <= 1'b0;
      check("refusal code", got, {8'h00, codes[i]});
      status_is("execution error", 8'h10);
    end
    query(event_status_pkg::OP_GET_ENABLE, got);
    check("mask kept", got, 16'h0008);
    ctrl.stray_read();
    status_is("empty read", 8'h04);
    cmd(event_status_pkg::OP_GET_ENABLE, 1'b0, 8'h00);
    cmd(event_status_pkg::OP_OP_COMPLETE, 1'b0, 8'h00);
    status_is("flushed answer", 8'h05);
    report_and_stop();
  end
endmodule : test_event_status_reporting
